// >>> sct_core_timing.sv
// Instruction timing, address latch enable and external data strobes of the single-cycle core.
//
// Function
// RULE1: One machine cycle equals one core clock; counts are in clocks.
// RULE2: External data move takes four clocks, plus one per wait state.
// RULE3: Long call entering an interrupt routine takes three clocks.
// RULE4: Timers advance once on every core clock.
// RULE5: One-cycle instruction: latch enable high first half, low second half.
// RULE6: Longer instruction: latch enable high only in first half of first cycle.
// RULE7: No external instruction fetch; bus serves external data moves only.
// RULE8: Wait-state register holds zero to seven and resets to zero.
// RULE9: External moves are one byte; 8-bit or 16-bit address by pointer kind.
// RULE10: Code-byte reads relative to accumulator take four clocks.
// RULE11: Indirect jump and two-byte branches take three clocks.
// RULE12: Three-byte branches and returns take four clocks.
// RULE13: Accumulator-to-register moves one clock; indirect moves two clocks.
// RULE14: Three-byte moves take three clocks.
// RULE15: Push and pop of a direct byte take two clocks.
// RULE16: Exchange with register one clock; indirect, nibble or direct two.
// RULE17: Carry-only operations one clock; direct-bit operations two clocks.
// RULE18: Accumulator clear, complement, swap and rotates take one clock.
// RULE19: Exclusive-or of immediate into direct byte takes three clocks.
// RULE20: Low address byte and data share the same eight pins in turn.
// RULE21: Each wait state stretches the read or write strobe by one clock.
// RULE22: External memory answers within the stretched strobe window.
`timescale 1ns/100ps
`default_nettype none
module sct_core_timing import sct_pkg::*; #(
	parameter int TIMER_WIDTH = 16
) (
	input wire logic clk, // Core clock, 100 MHz.
	input wire logic rst_n, // Asynchronous reset, active low.
	input wire logic issue_valid, // Core offers an instruction.
	input wire sct_issue_t issue, // The instruction offered.
	output logic issue_ready, // Instruction taken this cycle when valid.
	output logic instr_done, // Last clock of the running instruction.
	output logic [3:0] instr_cycles, // Clock count of the running instruction.
	input wire logic sfr_wr, // Special register write strobe.
	input wire logic sfr_rd, // Special register read strobe.
	input wire logic [7:0] sfr_addr, // Special register address.
	input wire logic [7:0] sfr_wdata, // Special register write data.
	output logic [7:0] sfr_rdata, // Read data, one clock after the strobe.
	output logic ale, // Address latch enable pin.
	output logic [7:0] ad_out, // Multiplexed address/data pins, driven value.
	output logic ad_oe, // Multiplexed pins driven while high.
	input wire logic [7:0] ad_in, // Multiplexed pins, sampled value.
	output logic [7:0] addr_hi, // High address byte pins.
	output logic addr_hi_oe, // High address pins driven while high.
	output logic rd_n, // External read strobe, active low.
	output logic wr_n, // External write strobe, active low.
	output logic [7:0] ext_rdata, // Byte read by the last external move.
	output logic ext_rvalid, // One-clock pulse with ext_rdata.
	input wire logic timer_run, // Timer runs while high.
	input wire logic timer_clear, // Timer synchronous clear.
	output logic [TIMER_WIDTH-1:0] timer_count // Timer value.
);

	initial begin
		if (TIMER_WIDTH < 2 || TIMER_WIDTH > 32) begin
			$error("sct_core_timing: TIMER_WIDTH must lie between 2 and 32.");
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Clock counts per instruction class.

	// Maps a class to its length in clocks, one machine cycle being one clock.
	function automatic logic [3:0] class_cycles(input sct_class_t c, input logic irq, input logic [2:0] ws);
		logic [3:0] n;
		n = SCT_CYC_ONE;
		case (c)
			SCT_NOP, SCT_ACC_TO_REG, SCT_XCH_REG: n = SCT_CYC_ONE; // RULE13 RULE16
			SCT_BOOL_CARRY, SCT_ACC_OP: n = SCT_CYC_ONE; // RULE17 RULE18
			SCT_INDIRECT_MOVE, SCT_DIRECT_MOVE: n = SCT_CYC_TWO; // RULE13
			SCT_PUSH_POP: n = SCT_CYC_TWO; // RULE15
			SCT_XCH_IND, SCT_XCH_DIR: n = SCT_CYC_TWO; // RULE16
			SCT_BOOL_BIT: n = SCT_CYC_TWO; // RULE17
			SCT_MOVE3: n = SCT_CYC_THREE; // RULE14
			SCT_XOR_IMM_DIR: n = SCT_CYC_THREE; // RULE19
			SCT_JMP_INDIRECT, SCT_BRANCH2: n = SCT_CYC_THREE; // RULE11
			SCT_CODE_BYTE_READ: n = SCT_CYC_FOUR; // RULE10
			SCT_BRANCH3, SCT_RETURN: n = SCT_CYC_FOUR; // RULE12
			SCT_LONG_CALL: n = irq ? SCT_CYC_IRQ_CALL : SCT_CYC_FOUR; // RULE3 RULE12
			SCT_EXTERNAL_DATA_MOVE: n = SCT_CYC_EXT_BASE + {1'b0, ws}; // RULE2
			default: n = SCT_CYC_ONE;
		endcase
		return n;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Wait-state register.

	logic [2:0] wait_states;
	logic sfr_hit;

	assign sfr_hit = (sfr_addr == SCT_WAIT_ADDR);

	// Only the low three bits exist, so the value stays within zero to seven.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wait_states <= SCT_WAIT_RESET[SCT_WAIT_BITS-1:0]; // RULE8
		end else if (sfr_wr && sfr_hit) begin
			wait_states <= sfr_wdata[SCT_WAIT_BITS-1:0]; // RULE8
		end
	end

	// Registered read port; unused bits and other addresses read zero.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sfr_rdata <= 8'h00;
		end else if (sfr_rd && sfr_hit) begin
			sfr_rdata <= {5'h00, wait_states};
		end else begin
			sfr_rdata <= 8'h00;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Instruction sequencer.

	sct_state_t state;
	sct_state_t next_state;
	logic [3:0] cnt;
	logic [3:0] next_cnt;
	logic [3:0] len;
	logic [2:0] ws_q;
	sct_issue_t req;
	sct_issue_t next_req;
	logic [2:0] next_ws;
	logic accept;
	logic last;

	assign last = (state == SCT_EXEC) && (cnt == len - 4'h1);
	assign issue_ready = (state == SCT_IDLE) || last;
	assign accept = issue_valid && issue_ready;
	assign instr_done = last;
	assign instr_cycles = len;

	// Next state: a new instruction may follow in the clock after the last one.
	always_comb begin
		next_state = state;
		next_cnt = cnt;
		next_req = req;
		next_ws = ws_q;
		if (accept) begin
			next_state = SCT_EXEC;
			next_cnt = 4'h0;
			next_req = issue;
			next_ws = wait_states;
		end else begin
			case (state)
				SCT_IDLE: begin
					next_cnt = 4'h0;
				end
				SCT_EXEC: begin
					if (last) begin
						next_state = SCT_IDLE;
						next_cnt = 4'h0;
					end else begin
						next_cnt = cnt + 4'h1; // RULE1
					end
				end
				default: begin
					next_state = SCT_IDLE;
				end
			endcase
		end
	end

	// Sequencer registers; the snapshot of the wait count holds for the whole move.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= SCT_IDLE;
			cnt <= 4'h0;
			len <= SCT_CYC_ONE;
			ws_q <= 3'h0;
			req <= '0;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
			ws_q <= next_ws;
			req <= next_req;
			if (accept) begin
				len <= class_cycles(issue.iclass, issue.irq_call, wait_states); // RULE1
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Address latch enable.

	logic ale_first;

	// High through the first clock of every instruction; the pin gates it with the clock high phase.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ale_first <= 1'b0;
		end else begin
			ale_first <= (next_state == SCT_EXEC) && (next_cnt == 4'h0); // RULE5 RULE6
		end
	end

	assign ale = ale_first & clk; // RULE5 RULE6

	////////////////////////////////////////////////////////////////////////////////
	// External data bus.

	logic next_ext;
	logic [3:0] next_strobe_end;
	logic next_strobe;

	// Only an external data move ever touches the bus; no fetch path exists.
	assign next_ext = (next_state == SCT_EXEC) && (next_req.iclass == SCT_EXTERNAL_DATA_MOVE); // RULE7 RULE9
	assign next_strobe_end = SCT_EXT_STROBE_BASE + {1'b0, next_ws};
	assign next_strobe = next_ext && (next_cnt >= SCT_EXT_STROBE_CYC) && (next_cnt <= next_strobe_end); // RULE21

	// Pins come from flops: address in the first clock, then data during the strobe.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ad_out <= 8'h00;
			ad_oe <= 1'b0;
			addr_hi <= 8'h00;
			addr_hi_oe <= 1'b0;
			rd_n <= 1'b1;
			wr_n <= 1'b1;
		end else begin
			ad_out <= 8'h00;
			ad_oe <= 1'b0;
			rd_n <= 1'b1;
			wr_n <= 1'b1;
			addr_hi_oe <= next_ext && next_req.ext_wide; // RULE9
			addr_hi <= (next_ext && next_req.ext_wide) ? next_req.ext_addr[15:8] : 8'h00; // RULE9
			if (next_ext && next_cnt == SCT_EXT_ADDR_CYC) begin
				ad_out <= next_req.ext_addr[7:0]; // RULE20
				ad_oe <= 1'b1;
			end else if (next_strobe) begin
				ad_out <= next_req.ext_write ? next_req.ext_wdata : 8'h00; // RULE20
				ad_oe <= next_req.ext_write;
				rd_n <= next_req.ext_write; // RULE21
				wr_n <= !next_req.ext_write; // RULE21
			end
		end
	end

	logic capture;

	// The read byte is taken at the end of the last strobe clock.
	assign capture = (state == SCT_EXEC) && (req.iclass == SCT_EXTERNAL_DATA_MOVE) && !req.ext_write
		&& (cnt == SCT_EXT_STROBE_BASE + {1'b0, ws_q}); // RULE22

	// Read data register and its valid pulse.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ext_rdata <= 8'h00;
			ext_rvalid <= 1'b0;
		end else begin
			ext_rvalid <= capture;
			if (capture) begin
				ext_rdata <= ad_in; // RULE22
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Timer.

	sct_tick_timer #(
		.WIDTH(TIMER_WIDTH)
	) u_timer (
		.clk(clk),
		.rst_n(rst_n),
		.run(timer_run),
		.clear(timer_clear),
		.count(timer_count)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Assertions.

	a_one_clock_ops: assert property (@(posedge clk) disable iff (!rst_n) // RULE1
		(accept && class_cycles(issue.iclass, issue.irq_call, wait_states) == SCT_CYC_ONE) |=> instr_done)
		else $error("One-clock instruction did not finish in its first clock.");

	a_ext_move_len: assert property (@(posedge clk) disable iff (!rst_n) // RULE2
		(accept && issue.iclass == SCT_EXTERNAL_DATA_MOVE && wait_states == 3'h0)
		|-> ##1 !instr_done ##1 !instr_done ##1 !instr_done ##1 instr_done)
		else $error("External move without wait states did not take four clocks.");

	a_irq_call_len: assert property (@(posedge clk) disable iff (!rst_n) // RULE3
		(accept && issue.iclass == SCT_LONG_CALL && issue.irq_call) |-> ##1 !instr_done ##1 !instr_done ##1 instr_done)
		else $error("Interrupt long call did not take three clocks.");

	a_branch3_len: assert property (@(posedge clk) disable iff (!rst_n) // RULE12
		(accept && (issue.iclass == SCT_BRANCH3 || issue.iclass == SCT_RETURN)) |-> ##4 instr_done)
		else $error("Three-byte branch or return did not take four clocks.");

	a_ale_first_only: assert property (@(posedge clk) disable iff (!rst_n) // RULE6
		(accept && class_cycles(issue.iclass, issue.irq_call, wait_states) != SCT_CYC_ONE) |=> ale_first ##1 !ale_first)
		else $error("Latch enable was active beyond the first clock.");

	a_ale_each_instr: assert property (@(posedge clk) disable iff (!rst_n) accept |=> ale_first) // RULE5
		else $error("Latch enable missing in the first clock of an instruction.");

	a_bus_quiet_idle: assert property (@(posedge clk) disable iff (!rst_n) // RULE7
		(req.iclass != SCT_EXTERNAL_DATA_MOVE || state == SCT_IDLE) |-> (!ad_oe && rd_n && wr_n))
		else $error("Bus driven outside an external data move.");

	a_wait_reg_range: assert property (@(posedge clk) disable iff (!rst_n) // RULE8
		(sfr_wr && sfr_hit) |=> wait_states == 3'($past(sfr_wdata)) && wait_states <= SCT_WAIT_MAX)
		else $error("Wait-state register did not take the written value.");

	a_read_strobe_ws0: assert property (@(posedge clk) disable iff (!rst_n) // RULE20 RULE21
		(accept && issue.iclass == SCT_EXTERNAL_DATA_MOVE && !issue.ext_write && wait_states == 3'h0)
		|-> ##1 (ad_oe && rd_n) ##1 (!rd_n && !ad_oe) ##1 !rd_n ##1 rd_n)
		else $error("Read strobe timing wrong with no wait states.");

	a_write_strobe_ws7: assert property (@(posedge clk) disable iff (!rst_n) // RULE21
		(accept && issue.iclass == SCT_EXTERNAL_DATA_MOVE && issue.ext_write && wait_states == 3'h7)
		|-> ##2 (!wr_n [*8]) ##1 !wr_n ##1 wr_n)
		else $error("Write strobe not stretched by seven wait states.");

	a_short_addr_hi: assert property (@(posedge clk) disable iff (!rst_n) // RULE9
		(accept && issue.iclass == SCT_EXTERNAL_DATA_MOVE && !issue.ext_wide) |=> !addr_hi_oe)
		else $error("High address driven for an 8-bit external move.");

	// Pin checks of an external data move, phase by phase, for any wait count; the read stretch check uses two wait states only.
	// The expected length uses the wait count as it stood at the taking edge.

	a_ext_cycles_ws: assert property (@(posedge clk) disable iff (!rst_n) // RULE2
		(accept && issue.iclass == SCT_EXTERNAL_DATA_MOVE)
		|=> instr_cycles == SCT_CYC_EXT_BASE + {1'b0, $past(wait_states)})
		else $error("External move length differs from four plus the wait count.");

	a_addr_phase: assert property (@(posedge clk) disable iff (!rst_n) // RULE20
		(accept && issue.iclass == SCT_EXTERNAL_DATA_MOVE)
		|=> (ad_oe && rd_n && wr_n && ad_out == req.ext_addr[7:0]))
		else $error("Low address byte not shown in the first clock of an external move.");

	a_write_data: assert property (@(posedge clk) disable iff (!rst_n) // RULE20 RULE21
		(accept && issue.iclass == SCT_EXTERNAL_DATA_MOVE && issue.ext_write)
		|-> ##2 (ad_oe && !wr_n && rd_n && ad_out == req.ext_wdata))
		else $error("Write data not on the shared pins during the write strobe.");

	a_wide_addr_hi: assert property (@(posedge clk) disable iff (!rst_n) // RULE9
		(accept && issue.iclass == SCT_EXTERNAL_DATA_MOVE && issue.ext_wide)
		|=> (addr_hi_oe && addr_hi == req.ext_addr[15:8]))
		else $error("High address byte missing for a 16-bit external move.");

	a_strobe_excl: assert property (@(posedge clk) disable iff (!rst_n) // RULE21
		!(!rd_n && !wr_n))
		else $error("Read and write strobes active together.");

	a_read_stretch: assert property (@(posedge clk) disable iff (!rst_n) // RULE21
		(accept && issue.iclass == SCT_EXTERNAL_DATA_MOVE && !issue.ext_write && wait_states == 3'h2)
		|-> ##2 (!rd_n [*4]) ##1 rd_n)
		else $error("Read strobe not stretched by two wait states.");

	a_read_capture: assert property (@(posedge clk) disable iff (!rst_n) // RULE22
		capture |=> (ext_rvalid && ext_rdata == $past(ad_in)))
		else $error("Read byte not taken at the end of the read strobe.");

	a_sfr_readback: assert property (@(posedge clk) disable iff (!rst_n) // RULE8
		(sfr_rd && sfr_hit) |=> sfr_rdata == {5'h00, $past(wait_states)})
		else $error("Wait-state register read back a wrong value.");

endmodule
`default_nettype wire

// >>> sct_ext_ram.sv
// Behavioural external data RAM on the multiplexed address/data bus.
`timescale 1ns/100ps
`default_nettype none
module sct_ext_ram (
	input wire logic clk, // Core clock.
	input wire logic [7:0] ad_out, // Multiplexed pins as driven by the core.
	input wire logic ad_oe, // Core drives the multiplexed pins.
	input wire logic [7:0] addr_hi, // High address pins.
	input wire logic addr_hi_oe, // High address pins driven.
	input wire logic rd_n, // Read strobe, active low.
	input wire logic wr_n, // Write strobe, active low.
	output logic [7:0] ad_in // Multiplexed pins as seen by the core.
);
	logic [7:0] mem [0:65535];
	logic [15:0] addr;
	logic [7:0] last;
	////////////////////////////////////////////////////////////////
	// Fill the array with a known pattern so reads are predictable.
	initial begin
		for (int i = 0; i < 65536; i++) begin
			mem[i] = 8'(i) ^ 8'h5A;
		end
		addr = 16'h0000;
		last = 8'h00;
	end
	// Latch the address while the core shows it with no strobe active.
	always @(posedge clk) begin
		if (ad_oe && rd_n && wr_n) begin
			addr <= {addr_hi_oe ? addr_hi : 8'h00, ad_out};
		end
		if (!wr_n && ad_oe) begin
			mem[addr] <= ad_out;
		end
		last <= last + 8'h01;
	end
	// Drive data only inside the read strobe; otherwise show a changing pattern.
	assign ad_in = !rd_n ? mem[addr] : ~last;
endmodule
`default_nettype wire

// >>> sct_pkg.sv
// Shared constants, instruction classes and carriers for the single-cycle core timing block.
package sct_pkg;

	// Register map: the wait-state register and its reset value.
	localparam logic [7:0] SCT_WAIT_ADDR = 8'h9F;
	localparam logic [7:0] SCT_WAIT_RESET = 8'h00;
	localparam int SCT_WAIT_BITS = 3;
	localparam logic [2:0] SCT_WAIT_MAX = 3'h7;

	// Clock counts of the instruction classes, one machine cycle being one clock.
	localparam logic [3:0] SCT_CYC_ONE = 4'h1;
	localparam logic [3:0] SCT_CYC_TWO = 4'h2;
	localparam logic [3:0] SCT_CYC_THREE = 4'h3;
	localparam logic [3:0] SCT_CYC_FOUR = 4'h4;
	localparam logic [3:0] SCT_CYC_EXT_BASE = 4'h4;
	localparam logic [3:0] SCT_CYC_IRQ_CALL = 4'h3;

	// Phase positions of an external data move inside its clock count.
	localparam logic [3:0] SCT_EXT_ADDR_CYC = 4'h0;
	localparam logic [3:0] SCT_EXT_STROBE_CYC = 4'h1;
	localparam logic [3:0] SCT_EXT_STROBE_BASE = 4'h2;

	// Instruction classes that the core sequencer hands over.
	typedef enum logic [4:0] {
		SCT_NOP = 5'h00,
		SCT_ACC_TO_REG = 5'h01,
		SCT_INDIRECT_MOVE = 5'h02,
		SCT_DIRECT_MOVE = 5'h03,
		SCT_MOVE3 = 5'h04,
		SCT_PUSH_POP = 5'h05,
		SCT_XCH_REG = 5'h06,
		SCT_XCH_IND = 5'h07,
		SCT_XCH_DIR = 5'h08,
		SCT_BOOL_CARRY = 5'h09,
		SCT_BOOL_BIT = 5'h0A,
		SCT_ACC_OP = 5'h0B,
		SCT_XOR_IMM_DIR = 5'h0C,
		SCT_CODE_BYTE_READ = 5'h0D,
		SCT_JMP_INDIRECT = 5'h0E,
		SCT_BRANCH2 = 5'h0F,
		SCT_BRANCH3 = 5'h10,
		SCT_RETURN = 5'h11,
		SCT_LONG_CALL = 5'h12,
		SCT_EXTERNAL_DATA_MOVE = 5'h13
	} sct_class_t;

	// Sequencer states, one-hot.
	typedef enum logic [1:0] {
		SCT_IDLE = 2'b01,
		SCT_EXEC = 2'b10
	} sct_state_t;

	// One instruction as issued by the core sequencer.
	typedef struct packed {
		sct_class_t iclass;
		logic irq_call;
		logic ext_write;
		logic ext_wide;
		logic [15:0] ext_addr;
		logic [7:0] ext_wdata;
	} sct_issue_t;

endpackage

// >>> sct_tick_timer.sv
// Timer that advances once per core clock while running.
`timescale 1ns/100ps
`default_nettype none
module sct_tick_timer import sct_pkg::*; #(
	parameter int WIDTH = 16
) (
	input wire logic clk, // Core clock.
	input wire logic rst_n, // Asynchronous reset, active low.
	input wire logic run, // Count while high.
	input wire logic clear, // Synchronous clear to zero.
	output logic [WIDTH-1:0] count // Current count.
);

	initial begin
		if (WIDTH < 2) begin
			$error("sct_tick_timer: WIDTH must be at least 2.");
		end
	end

	// One machine cycle is one clock, so the count moves on every rising clock edge while run is high and clear is low.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			count <= '0;
		end else if (clear) begin
			count <= '0;
		end else if (run) begin
			count <= count + WIDTH'(1); // RULE4
		end
	end

	a_timer_step: assert property (@(posedge clk) disable iff (!rst_n) // RULE4
		(run && !clear) |=> count == $past(count) + WIDTH'(1))
		else $error("Timer did not advance by one on a core clock.");

endmodule
`default_nettype wire

// >>> single_cycle_core_timing_test.sv
// Self-checking testbench for the single-cycle core timing block.
`timescale 1ns/100ps
`default_nettype none
module single_cycle_core_timing_test;
	import sct_pkg::*;
	typedef struct packed {sct_class_t c; logic irq; logic [3:0] len;} sct_row_t;
	logic clk = 1'h0, rst_n = 1'h0, issue_valid = 1'h0, sfr_wr = 1'h0, sfr_rd = 1'h0;
	logic timer_run = 1'h0, timer_clear = 1'h0;
	logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00;
	sct_issue_t issue = '0;
	logic issue_ready, instr_done, ale, ad_oe, addr_hi_oe, rd_n, wr_n, ext_rvalid;
	logic [3:0] instr_cycles;
	logic [7:0] sfr_rdata, ad_out, ad_in, addr_hi, ext_rdata;
	logic [15:0] timer_count;
	int fail_count = 0, num_checks = 0;
	sct_row_t rows [0:19] = '{
		'{SCT_NOP, 1'h0, 4'h1}, '{SCT_ACC_TO_REG, 1'h0, 4'h1}, '{SCT_XCH_REG, 1'h0, 4'h1},
		'{SCT_BOOL_CARRY, 1'h0, 4'h1}, '{SCT_ACC_OP, 1'h0, 4'h1}, '{SCT_INDIRECT_MOVE, 1'h0, 4'h2},
		'{SCT_DIRECT_MOVE, 1'h0, 4'h2}, '{SCT_PUSH_POP, 1'h0, 4'h2}, '{SCT_XCH_IND, 1'h0, 4'h2},
		'{SCT_XCH_DIR, 1'h0, 4'h2}, '{SCT_BOOL_BIT, 1'h0, 4'h2}, '{SCT_MOVE3, 1'h0, 4'h3},
		'{SCT_XOR_IMM_DIR, 1'h0, 4'h3}, '{SCT_JMP_INDIRECT, 1'h0, 4'h3}, '{SCT_BRANCH2, 1'h0, 4'h3},
		'{SCT_LONG_CALL, 1'h1, 4'h3}, '{SCT_LONG_CALL, 1'h0, 4'h4}, '{SCT_BRANCH3, 1'h0, 4'h4},
		'{SCT_RETURN, 1'h0, 4'h4}, '{SCT_CODE_BYTE_READ, 1'h0, 4'h4}};
	sct_core_timing i_dut (.clk(clk), .rst_n(rst_n), .issue_valid(issue_valid), .issue(issue),
		.issue_ready(issue_ready), .instr_done(instr_done), .instr_cycles(instr_cycles), .sfr_wr(sfr_wr),
		.sfr_rd(sfr_rd), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .ale(ale),
		.ad_out(ad_out), .ad_oe(ad_oe), .ad_in(ad_in), .addr_hi(addr_hi), .addr_hi_oe(addr_hi_oe),
		.rd_n(rd_n), .wr_n(wr_n), .ext_rdata(ext_rdata), .ext_rvalid(ext_rvalid), .timer_run(timer_run),
		.timer_clear(timer_clear), .timer_count(timer_count));
	sct_ext_ram i_ram (.clk(clk), .ad_out(ad_out), .ad_oe(ad_oe), .addr_hi(addr_hi),
		.addr_hi_oe(addr_hi_oe), .rd_n(rd_n), .wr_n(wr_n), .ad_in(ad_in));
	////////////////////////////////////////////////////////////////
	// Clock of 100 MHz.
	always #5 clk = ~clk;
	// Compare a seen value with the expected one and count the result.
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// Print the verdict and end the run.
	task automatic report_and_stop;
		if (fail_count == 0 && num_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// Hold reset low for five clocks.
	task automatic do_reset;
		@(posedge clk) rst_n <= 1'h0;
		repeat (5) @(posedge clk);
		rst_n <= 1'h1;
	endtask
	// Register access: a one-clock strobe, read data checked the clock after.
	task automatic sfr(input logic wr, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk) begin
			sfr_wr <= wr;
			sfr_rd <= !wr;
			sfr_addr <= a;
			sfr_wdata <= d;
		end
		@(posedge clk) begin
			sfr_wr <= 1'h0;
			sfr_rd <= 1'h0;
		end
		#1;
		if (!wr) chk(sfr_rdata, d);
	endtask
	// Issue one instruction and follow it clock by clock to its last clock.
	task automatic run(input sct_class_t c, input logic irq, input logic wr, input logic wide,
		input logic [15:0] a, input logic [7:0] d, input logic [3:0] len);
		int n, s;
		logic ext;
		ext = (c == SCT_EXTERNAL_DATA_MOVE);
		@(posedge clk) begin
			issue_valid <= 1'h1;
			issue <= '{c, irq, wr, wide, a, d};
		end
		@(posedge clk) issue_valid <= 1'h0;
		n = 1;
		s = 0;
		forever begin
			#1;
			chk(ale, 16'(n == 1));
			if (!rd_n || !wr_n) begin
				s++;
				chk({rd_n, wr_n}, {wr, !wr});
			end
			if (!ext) chk({ad_oe, rd_n, wr_n}, 3'h3);
			if (ext && n == 1) chk({ad_oe, addr_hi_oe, ad_out}, {1'h1, wide, a[7:0]});
			if (ext && wide && n == 1) chk(addr_hi, a[15:8]);
			if (ext && wr && n == 2) chk({ad_oe, ad_out}, {1'h1, d});
			if (n == 1) begin
				@(negedge clk) #1;
				chk(ale, 1'h0);
			end
			if (instr_done || n > 20) break;
			@(posedge clk);
			n++;
		end
		chk(16'(n), len);
		chk(instr_cycles, len);
		if (ext) chk(16'(s), 16'(len) - 16'h2);
		if (ext && !wr) chk({ext_rvalid, ext_rdata}, {1'h1, d});
		if (ext && wr) chk(ext_rvalid, 1'h0);
	endtask
	////////////////////////////////////////////////////////////////
	// Watchdog against a hang.
	initial begin
		repeat (3000) @(posedge clk);
		fail_count++;
		report_and_stop;
	end
	// Main sequence: table of classes, then registers, bus moves, timer and reset cases.
	initial begin
		do_reset;
		foreach (rows[i]) run(rows[i].c, rows[i].irq, 1'h0, 1'h0, 16'h0000, 8'h00, rows[i].len);
		sfr(1'h0, SCT_WAIT_ADDR, SCT_WAIT_RESET);
		sfr(1'h1, SCT_WAIT_ADDR, 8'hFF);
		sfr(1'h0, SCT_WAIT_ADDR, 8'h07);
		sfr(1'h0, 8'h9E, 8'h00);
		run(SCT_EXTERNAL_DATA_MOVE, 1'h0, 1'h1, 1'h1, 16'h1234, 8'hA5, 4'hB);
		sfr(1'h1, SCT_WAIT_ADDR, 8'h02);
		run(SCT_EXTERNAL_DATA_MOVE, 1'h0, 1'h0, 1'h1, 16'h1234, 8'hA5, 4'h6);
		sfr(1'h1, SCT_WAIT_ADDR, 8'h00);
		run(SCT_EXTERNAL_DATA_MOVE, 1'h0, 1'h0, 1'h0, 16'h1234, 8'h34 ^ 8'h5A, 4'h4);
		// Back-to-back one-clock instructions finish every clock.
		@(posedge clk) begin
			issue_valid <= 1'h1;
			issue <= '0;
		end
		repeat (3) begin
			@(posedge clk) #1;
			chk({issue_ready, instr_done}, 2'h3);
		end
		@(posedge clk) issue_valid <= 1'h0;
		// Timer advances on every clock while running.
		@(posedge clk) timer_clear <= 1'h1;
		@(posedge clk) begin
			timer_clear <= 1'h0;
			timer_run <= 1'h1;
		end
		repeat (10) @(posedge clk);
		timer_run <= 1'h0;
		@(posedge clk) #1;
		chk(timer_count, 16'hA);
		// A second reset clears the wait-state register again.
		sfr(1'h1, SCT_WAIT_ADDR, 8'h05);
		do_reset;
		sfr(1'h0, SCT_WAIT_ADDR, SCT_WAIT_RESET);
		report_and_stop;
	end
endmodule
`default_nettype wire
